// ### src/smcp_pkg.sv
/*
 smcp_pkg: constants, state codes and limits of the serial master port.
 assumes a 250 MHz sys_clk; every user of it writes smcp_pkg::name.
*/
package smcp_pkg;

  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned SPI_SCLK_MAX_HZ = 20_000_000;
  localparam int unsigned SPI_SCLK_MIN_HZ = 2_300;
  localparam int unsigned I2C_SCL_MAX_HZ  = 400_000;
  localparam int unsigned I2C_SCL_MIN_HZ  = 20_000;

  // spi ticks every half period, i2c every quarter period
  localparam int unsigned SPI_HALF_MIN =
    (CLK_HZ + 2 * SPI_SCLK_MAX_HZ - 1) / (2 * SPI_SCLK_MAX_HZ);
  localparam int unsigned SPI_HALF_MAX = CLK_HZ / (2 * SPI_SCLK_MIN_HZ);
  localparam int unsigned I2C_QTR_MIN  =
    (CLK_HZ + 4 * I2C_SCL_MAX_HZ - 1) / (4 * I2C_SCL_MAX_HZ);
  localparam int unsigned I2C_QTR_MAX  = CLK_HZ / (4 * I2C_SCL_MIN_HZ);

  localparam int unsigned DIV_W     = 16;
  localparam int unsigned BUF_BYTES = 16;
  localparam int unsigned BUF_BITS  = 128;
  localparam int unsigned LEN_W     = 5;
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned SEC_SEL   = 6;

  localparam logic [3:0]       LAST_BIT  = 4'h7;
  localparam logic [3:0]       ACK_BIT   = 4'h8;
  localparam logic [LEN_W-1:0] LEN_MAX   = 5'h10;
  localparam logic             MODE0_RST = 1'b0;
  localparam logic             SCLK_RST  = 1'b1;

  typedef enum logic [8:0] {
    ST_OFF       = 9'h001,
    ST_IDLE      = 9'h002,
    ST_SPI_LEAD  = 9'h004,
    ST_SPI_LOW   = 9'h008,
    ST_SPI_HIGH  = 9'h010,
    ST_SPI_TRAIL = 9'h020,
    ST_I2C_START = 9'h040,
    ST_I2C_BIT   = 9'h080,
    ST_I2C_STOP  = 9'h100
  } smcp_state_type;

endpackage

// ### src/smcp_tick_gen.sv
/*
 smcp_tick_gen: one-cycle tick every period cycles while run is high.
 assumes period is at least 1 and stable while run is high.
*/
`timescale 1ns/1ps
module smcp_tick_gen #(
  parameter int unsigned W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } smcp_tick_type;

  smcp_tick_type r;
  smcp_tick_type next_r;

  if (W < 2) begin : g_bad_width
    $error("smcp_tick_gen: W must be at least 2");
  end

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (!run) begin
      next_r.cnt = '0;
    end else if (r.cnt >= period - W'(1)) begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule // smcp_tick_gen

// ### src/smcp_master.sv
/*
 smcp_master: combined spi / i2c serial master port on shared pins.
 assumes pins are resolved outside from out/oe, external i2c pull-ups,
 and a single requester on the command port in the sys_clk domain.
*/
// Operation
// - at most 128 bits of transfer data are buffered per transfer
// - transfers consist of whole bytes, eight bits each
// - only one protocol, spi or i2c, drives the shared pins
// - port is enabled by the boot sequence or by a core command
// - spi reaches up to seven slaves, one select line each
// - spi clock programmable between 2.3 kHz and 20 MHz
// - after reset spi runs mode 3, clock idle high
// - program can switch spi to mode 0, clock idle low
// - spi is half duplex on separate out and in lines
// - spi does no error detection or handling
// - i2c slaves use 7-bit addresses only
// - i2c clock programmable between 20 kHz and 400 kHz
// - i2c has no bus variants and no error detection
// - i2c clock and data pins are open collector
// - spi drives data out, clock, primary select; samples data in
// - extra pins may serve as secondary selects, one slave each
// - boot uses i2c when primary select pin is low, else spi
`timescale 1ns/1ps
module smcp_master #(
  parameter int unsigned SPI_HALF_MAX = smcp_pkg::SPI_HALF_MAX,
  parameter int unsigned SEC_SEL      = smcp_pkg::SEC_SEL
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  input  wire logic                            boot_start,
  input  wire logic                            core_enable,
  input  wire logic                            core_use_i2c,
  input  wire logic                            cfg_mode0,
  input  wire logic [SEC_SEL-1:0]              sec_sel_enable,
  input  wire logic                            cmd_valid,
  output logic                                 cmd_ready,
  input  wire logic [smcp_pkg::SEL_W-1:0]      cmd_select,
  input  wire logic [smcp_pkg::ADDR_W-1:0]     cmd_addr,
  input  wire logic                            cmd_read,
  input  wire logic [smcp_pkg::LEN_W-1:0]      cmd_len,
  input  wire logic [smcp_pkg::LEN_W-1:0]      cmd_wr_len,
  input  wire logic [smcp_pkg::DIV_W-1:0]      cmd_div,
  input  wire logic [smcp_pkg::BUF_BITS-1:0]   cmd_wdata,
  output logic [smcp_pkg::BUF_BITS-1:0]        rx_data,
  output logic                                 xfer_done,
  output logic                                 port_enabled,
  output logic                                 i2c_active,
  output logic                                 master_serial_out_pin_out,
  output logic                                 master_serial_out_pin_oe,
  input  wire logic                            master_serial_clock_pin_in,
  output logic                                 master_serial_clock_pin_out,
  output logic                                 master_serial_clock_pin_oe,
  input  wire logic                            master_serial_in_pin_in,
  output logic                                 master_serial_in_pin_out,
  output logic                                 master_serial_in_pin_oe,
  input  wire logic                            primary_select_pin_in,
  output logic                                 primary_select_pin_out,
  output logic                                 primary_select_pin_oe,
  output logic [SEC_SEL-1:0]                   secondary_select_pins_out,
  output logic [SEC_SEL-1:0]                   secondary_select_pins_oe
);

  localparam int unsigned DW = smcp_pkg::DIV_W;
  localparam int unsigned LW = smcp_pkg::LEN_W;

  typedef struct packed {
    smcp_pkg::smcp_state_type                      state;
    logic                                          enabled;
    logic                                          proto_i2c;
    logic                                          mode0;
    logic [smcp_pkg::SEL_W-1:0]                    sel;
    logic [LW-1:0]                                 len;
    logic [LW-1:0]                                 wr_len;
    logic [LW-1:0]                                 idx;
    logic [3:0]                                    bit_cnt;
    logic [1:0]                                    qtr;
    logic [7:0]                                    shreg;
    logic                                          addr_ph;
    logic                                          rd;
    logic                                          sclk;
    logic                                          mosi;
    logic                                          ss_act;
    logic                                          scl_low;
    logic                                          sda_low;
    logic [1:0]                                    din_s;
    logic [1:0]                                    strap_s;
    logic [1:0]                                    scl_s;
    logic                                          done;
    logic [smcp_pkg::BUF_BYTES-1:0][7:0]           buf_q;
    logic [DW-1:0]                                 div;
  } smcp_core_type;

  smcp_core_type r;
  smcp_core_type next_r;
  logic          tick;
  logic          spi_on;
  logic          last_byte;

  if (SEC_SEL < 1 || SEC_SEL > 6 || SPI_HALF_MAX < smcp_pkg::SPI_HALF_MIN
      || SPI_HALF_MAX >= (1 << DW)) begin : g_bad_param
    $error("smcp_master: SEC_SEL or SPI_HALF_MAX out of range");
  end

  function automatic logic [DW-1:0] clamp_div(input logic [DW-1:0] v,
                                              input logic [DW-1:0] lo,
                                              input logic [DW-1:0] hi);
    clamp_div = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [LW-1:0] fix_len(input logic [LW-1:0] v);
    fix_len = (v == '0) ? LW'(1) : ((v > smcp_pkg::LEN_MAX) ?
              smcp_pkg::LEN_MAX : v);
  endfunction

  smcp_tick_gen #(.W(DW)) u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (r.state != smcp_pkg::ST_OFF && r.state != smcp_pkg::ST_IDLE),
    .period  (r.div),
    .tick    (tick)
  );

  assign last_byte = (r.idx + LW'(1) == r.len);

  always_comb begin
    next_r = r;
    next_r.done    = 1'b0;
    next_r.din_s   = {r.din_s[0], master_serial_in_pin_in};
    next_r.strap_s = {r.strap_s[0], primary_select_pin_in};
    next_r.scl_s   = {r.scl_s[0], master_serial_clock_pin_in};
    unique case (r.state)
      smcp_pkg::ST_OFF, smcp_pkg::ST_IDLE: begin
        if (!r.proto_i2c) begin
          next_r.mode0 = cfg_mode0;
          next_r.sclk  = ~cfg_mode0;
        end
        if (boot_start) begin
          next_r.enabled   = 1'b1;
          next_r.proto_i2c = ~r.strap_s[1];
          next_r.state     = smcp_pkg::ST_IDLE;
        end else if (core_enable) begin
          next_r.enabled   = 1'b1;
          next_r.proto_i2c = core_use_i2c;
          next_r.state     = smcp_pkg::ST_IDLE;
        end else if (r.state == smcp_pkg::ST_IDLE && cmd_valid) begin
          next_r.len     = fix_len(cmd_len);
          next_r.wr_len  = (cmd_wr_len > fix_len(cmd_len)) ?
                           fix_len(cmd_len) : cmd_wr_len;
          next_r.sel     = cmd_select;
          next_r.rd      = cmd_read;
          next_r.buf_q   = cmd_wdata;
          next_r.idx     = '0;
          next_r.bit_cnt = '0;
          next_r.qtr     = '0;
          if (r.proto_i2c) begin
            next_r.div     = clamp_div(cmd_div, DW'(smcp_pkg::I2C_QTR_MIN),
                             DW'(smcp_pkg::I2C_QTR_MAX));
            next_r.shreg   = {cmd_addr, cmd_read};
            next_r.addr_ph = 1'b1;
            next_r.state   = smcp_pkg::ST_I2C_START;
          end else begin
            next_r.div    = clamp_div(cmd_div, DW'(smcp_pkg::SPI_HALF_MIN),
                            DW'(SPI_HALF_MAX));
            next_r.shreg  = cmd_wdata[7:0];
            next_r.mosi   = cmd_wdata[7];
            next_r.ss_act = 1'b1;
            next_r.state  = smcp_pkg::ST_SPI_LEAD;
          end
        end
      end
      smcp_pkg::ST_SPI_LEAD: begin
        if (tick) begin
          next_r.sclk  = 1'b0;
          next_r.state = smcp_pkg::ST_SPI_LOW;
        end
      end
      smcp_pkg::ST_SPI_LOW: begin
        if (tick) begin
          next_r.sclk  = 1'b1;
          next_r.shreg = {r.shreg[6:0], r.din_s[1]};
          next_r.state = smcp_pkg::ST_SPI_HIGH;
        end
      end
      smcp_pkg::ST_SPI_HIGH: begin
        if (tick) begin
          next_r.sclk = 1'b0;
          next_r.mosi = r.shreg[7];
          next_r.state = smcp_pkg::ST_SPI_LOW;
          next_r.bit_cnt = r.bit_cnt + 4'h1;
          if (r.bit_cnt == smcp_pkg::LAST_BIT) begin
            next_r.bit_cnt = '0;
            if (r.idx >= r.wr_len) begin
              next_r.buf_q[r.idx[3:0]] = r.shreg;
            end
            if (last_byte) begin
              next_r.sclk  = ~r.mode0;
              next_r.state = smcp_pkg::ST_SPI_TRAIL;
            end else begin
              next_r.idx   = r.idx + LW'(1);
              next_r.shreg = r.buf_q[r.idx[3:0] + 4'h1];
              next_r.mosi  = r.buf_q[r.idx[3:0] + 4'h1][7];
            end
          end
        end
      end
      smcp_pkg::ST_SPI_TRAIL: begin
        if (tick) begin
          next_r.ss_act = 1'b0;
          next_r.done   = 1'b1;
          next_r.state  = smcp_pkg::ST_IDLE;
        end
      end
      smcp_pkg::ST_I2C_START: begin
        if (tick) begin
          next_r.qtr = r.qtr + 2'h1;
          if (r.qtr == 2'h0) begin
            next_r.sda_low = 1'b1;
          end else begin
            next_r.scl_low = 1'b1;
            next_r.qtr     = '0;
            next_r.state   = smcp_pkg::ST_I2C_BIT;
          end
        end
      end
      smcp_pkg::ST_I2C_BIT: begin
        unique case (r.qtr)
          2'h0: if (tick) begin
            if (r.bit_cnt == smcp_pkg::ACK_BIT) begin
              // master acks read bytes except the last one
              next_r.sda_low = !r.addr_ph && r.rd && !last_byte;
            end else begin
              next_r.sda_low = (r.addr_ph || !r.rd) && !r.shreg[7];
            end
            next_r.qtr = 2'h1;
          end
          2'h1: if (tick) begin
            next_r.scl_low = 1'b0;
            next_r.qtr     = 2'h2;
          end
          2'h2: if (tick && r.scl_s[1]) begin
            if (r.bit_cnt != smcp_pkg::ACK_BIT) begin
              next_r.shreg = {r.shreg[6:0], r.din_s[1]};
            end
            next_r.qtr = 2'h3;
          end
          default: if (tick) begin
            next_r.scl_low = 1'b1;
            next_r.qtr     = 2'h0;
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            // acknowledge value is not checked
            if (r.bit_cnt == smcp_pkg::ACK_BIT) begin
              next_r.bit_cnt = '0;
              if (!r.addr_ph && r.rd) begin
                next_r.buf_q[r.idx[3:0]] = r.shreg;
              end
              if (r.addr_ph) begin
                next_r.addr_ph = 1'b0;
                next_r.shreg   = r.buf_q[0];
              end else if (last_byte) begin
                next_r.state = smcp_pkg::ST_I2C_STOP;
              end else begin
                next_r.idx   = r.idx + LW'(1);
                next_r.shreg = r.buf_q[r.idx[3:0] + 4'h1];
              end
            end
          end
        endcase
      end
      smcp_pkg::ST_I2C_STOP: begin
        unique case (r.qtr)
          2'h0: if (tick) begin
            next_r.sda_low = 1'b1;
            next_r.qtr     = 2'h1;
          end
          2'h1: if (tick) begin
            next_r.scl_low = 1'b0;
            next_r.qtr     = 2'h2;
          end
          default: if (tick && r.scl_s[1]) begin
            next_r.sda_low = 1'b0;
            next_r.qtr     = 2'h0;
            next_r.done    = 1'b1;
            next_r.state   = smcp_pkg::ST_IDLE;
          end
        endcase
      end
      default: next_r.state = smcp_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r       <= '0;
      r.state <= smcp_pkg::ST_OFF;
      r.mode0 <= smcp_pkg::MODE0_RST;
      r.sclk  <= smcp_pkg::SCLK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign spi_on       = r.enabled && !r.proto_i2c;
  assign cmd_ready    = (r.state == smcp_pkg::ST_IDLE) && !boot_start
                        && !core_enable;
  assign rx_data      = r.buf_q;
  assign xfer_done    = r.done;
  assign port_enabled = r.enabled;
  assign i2c_active   = r.enabled && r.proto_i2c;

  assign master_serial_out_pin_out   = r.mosi;
  assign master_serial_out_pin_oe    = spi_on;
  assign master_serial_clock_pin_out = r.proto_i2c ? 1'b0 : r.sclk;
  assign master_serial_clock_pin_oe  = r.enabled &&
                                       (r.proto_i2c ? r.scl_low : 1'b1);
  assign master_serial_in_pin_out    = 1'b0;
  assign master_serial_in_pin_oe     = i2c_active && r.sda_low;
  assign primary_select_pin_out      = ~(r.ss_act && r.sel == '0);
  assign primary_select_pin_oe       = spi_on;

  for (genvar i = 0; i < SEC_SEL; i++) begin : g_sec_sel
    assign secondary_select_pins_out[i] =
      ~(r.ss_act && r.sel == smcp_pkg::SEL_W'(i + 1));
    assign secondary_select_pins_oe[i] =
      spi_on && sec_sel_enable[i];
  end

  // rising spi clock edges within one select window
  logic [2:0] rise_cnt;
  logic       sclk_d;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rise_cnt <= '0;
      sclk_d   <= 1'b1;
    end else begin
      sclk_d <= r.sclk;
      if (!r.ss_act) begin
        rise_cnt <= '0;
      end else if (r.sclk && !sclk_d) begin
        rise_cnt <= rise_cnt + 3'h1;
      end
    end
  end

  property p_byte_whole;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(r.ss_act) |-> rise_cnt == 3'h0;
  endproperty
  a_byte_whole: assert property (p_byte_whole)
    else $error("spi select released inside a byte");

  property p_len_bound;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.state != smcp_pkg::ST_IDLE && r.state != smcp_pkg::ST_OFF)
      |-> (r.len != '0 && r.len <= 5'h10 && r.idx < r.len);
  endproperty
  a_len_bound: assert property (p_len_bound)
    else $error("transfer length exceeds buffer");

  property p_one_proto;
    @(posedge sys_clk) disable iff (!rst_n)
      i2c_active |-> !master_serial_out_pin_oe && !primary_select_pin_oe
                     && secondary_select_pins_oe == '0;
  endproperty
  a_one_proto: assert property (p_one_proto)
    else $error("spi pins driven in i2c mode");

  property p_one_select;
    @(posedge sys_clk) disable iff (!rst_n)
      $onehot0({~secondary_select_pins_out, ~primary_select_pin_out});
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("more than one slave selected");

  property p_sclk_high_min;
    @(posedge sys_clk) disable iff (!rst_n)
      ($rose(r.sclk) && r.ss_act && spi_on) |-> r.sclk [*7];
  endproperty
  a_sclk_high_min: assert property (p_sclk_high_min)
    else $error("spi clock high phase too short");

  property p_mode3_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (spi_on && r.state == smcp_pkg::ST_IDLE && !r.mode0)
      |-> master_serial_clock_pin_out && primary_select_pin_out;
  endproperty
  a_mode3_idle: assert property (p_mode3_idle)
    else $error("mode 3 clock not idle high");

  property p_mode0_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      (spi_on && r.state == smcp_pkg::ST_IDLE && r.mode0)
      |-> !master_serial_clock_pin_out;
  endproperty
  a_mode0_idle: assert property (p_mode0_idle)
    else $error("mode 0 clock not idle low");

  property p_half_duplex;
    @(posedge sys_clk) disable iff (!rst_n)
      spi_on |-> !master_serial_in_pin_oe && master_serial_out_pin_oe;
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("spi data in pin driven");

  property p_boot_strap;
    @(posedge sys_clk) disable iff (!rst_n)
      (boot_start && (r.state == smcp_pkg::ST_OFF
                      || r.state == smcp_pkg::ST_IDLE))
      |=> r.enabled && (r.proto_i2c == !$past(r.strap_s[1]));
  endproperty
  a_boot_strap: assert property (p_boot_strap)
    else $error("boot protocol does not follow select strap");

  property p_msb_first;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.state == smcp_pkg::ST_SPI_LEAD) |-> r.mosi == r.buf_q[0][7];
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first spi bit is not the msb");

endmodule // smcp_master

// ### verif/smcp_far_end.sv
/*
 smcp_far_end: spi and i2c slaves with pull-ups on the master's pins.
 assumes spi mode whenever the master drives its data out pin.
*/
`timescale 1ns/1ps
module smcp_far_end (
  input  wire logic       master_serial_out_pin_out,
  input  wire logic       master_serial_out_pin_oe,
  input  wire logic       master_serial_clock_pin_out,
  input  wire logic       master_serial_clock_pin_oe,
  input  wire logic       master_serial_in_pin_out,
  input  wire logic       master_serial_in_pin_oe,
  input  wire logic       primary_select_pin_out,
  input  wire logic       primary_select_pin_oe,
  input  wire logic [5:0] secondary_select_pins_out,
  input  wire logic [5:0] secondary_select_pins_oe,
  input  wire logic       strap,
  output logic            master_serial_clock_pin_in,
  output logic            master_serial_in_pin_in,
  output logic            primary_select_pin_in
);
  logic [7:0] sh, rb, spi_byte [16], i2c_byte [17];
  logic [6:0] sel_seen;
  logic [5:0] ssel;
  logic       miso = 1'b0, drv = 1'b0, rd = 1'b0, sda, scl, spi, sel_n;
  int         rises = 0, bitc = 0, nbyte = 0;
  assign spi = master_serial_out_pin_oe;
  assign scl = master_serial_clock_pin_oe ?
               master_serial_clock_pin_out : 1'b1;
  assign master_serial_clock_pin_in = scl;
  assign primary_select_pin_in = primary_select_pin_oe ?
                                 primary_select_pin_out : strap;
  assign ssel = secondary_select_pins_out | ~secondary_select_pins_oe;
  assign sel_n = primary_select_pin_in & (&ssel);
  // pulled up: low only while some party pulls it
  assign sda = !((master_serial_in_pin_oe && !master_serial_in_pin_out)
                 || drv);
  assign master_serial_in_pin_in = spi ? miso : sda;
  // slave only answers on miso, never drives the clock
  always @(negedge sel_n) begin
    rises = 0;
    sel_seen = {ssel, primary_select_pin_in};
    rb = 8'hc3;
    miso = rb[7];
  end
  always @(posedge sel_n) miso = ~miso;
  always @(posedge scl) if (spi && !sel_n) begin
    sh = {sh[6:0], master_serial_out_pin_out};
    rises = rises + 1;
    if (rises % 8 == 0) spi_byte[rises/8-1] = sh;
  end
  always @(negedge scl) if (spi && !sel_n) begin
    rb = 8'hc3 ^ 8'(rises / 8);
    miso = rb[7 - rises % 8];
  end
  always @(negedge sda) if (scl && !spi) begin
    bitc = 0;
    nbyte = 0;
    drv = 1'b0;
  end
  always @(posedge scl) if (!spi) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else if (sda) rd = 1'b0;  // master nack ends the read
    bitc = bitc + 1;
  end
  always @(negedge scl) if (!spi) begin
    if (bitc == 9) begin
      bitc = 0;
      nbyte = nbyte + 1;
    end
    if (bitc == 8) begin
      i2c_byte[nbyte] = sh;
      if (nbyte == 0) rd = sh[0];
      drv = !(rd && nbyte > 0);
    end else begin
      rb = 8'h5a ^ 8'(nbyte - 1);
      drv = rd && nbyte > 0 && !rb[7 - bitc];
    end
  end
endmodule  // smcp_far_end

// ### verif/tb.sv
/*
 tb: self-checking bench for smcp_master with the far-end slave model.
 assumes default parameters; inputs change at the falling clock edge.
*/
`timescale 1ns/1ps
module tb;
  logic         sys_clk = 1'b0, rst_n = 1'b0, strap = 1'b1;
  logic         boot_start = 1'b0, core_enable = 1'b0, core_use_i2c = 1'b0;
  logic         cfg_mode0 = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
  logic         cmd_ready, xfer_done, port_enabled, i2c_active;
  logic         master_serial_out_pin_out, master_serial_out_pin_oe;
  logic         master_serial_clock_pin_in, master_serial_clock_pin_out;
  logic         master_serial_clock_pin_oe, master_serial_in_pin_in;
  logic         master_serial_in_pin_out, master_serial_in_pin_oe;
  logic         primary_select_pin_in, primary_select_pin_out;
  logic         primary_select_pin_oe;
  logic [5:0]   sec_sel_enable = 6'h00;
  logic [5:0]   secondary_select_pins_out, secondary_select_pins_oe;
  logic [2:0]   cmd_select = 3'h0;
  logic [6:0]   cmd_addr = 7'h00;
  logic [4:0]   cmd_len = 5'h01, cmd_wr_len = 5'h00;
  logic [15:0]  cmd_div = 16'h0007;
  logic [127:0] cmd_wdata = 128'h0, rx_data, exp;
  int           n_fail = 0, cmp_count = 0, cyc = 0;
  always #2 sys_clk = ~sys_clk;
  smcp_master dut (
    .sys_clk, .rst_n, .boot_start, .core_enable, .core_use_i2c, .cfg_mode0,
    .sec_sel_enable, .cmd_valid, .cmd_ready, .cmd_select, .cmd_addr,
    .cmd_read, .cmd_len, .cmd_wr_len, .cmd_div, .cmd_wdata, .rx_data,
    .xfer_done, .port_enabled, .i2c_active, .master_serial_out_pin_out,
    .master_serial_out_pin_oe, .master_serial_clock_pin_in,
    .master_serial_clock_pin_out, .master_serial_clock_pin_oe,
    .master_serial_in_pin_in, .master_serial_in_pin_out,
    .master_serial_in_pin_oe, .primary_select_pin_in,
    .primary_select_pin_out, .primary_select_pin_oe,
    .secondary_select_pins_out, .secondary_select_pins_oe
  );
  smcp_far_end far (
    .master_serial_out_pin_out, .master_serial_out_pin_oe,
    .master_serial_clock_pin_out, .master_serial_clock_pin_oe,
    .master_serial_in_pin_out, .master_serial_in_pin_oe,
    .primary_select_pin_out, .primary_select_pin_oe,
    .secondary_select_pins_out, .secondary_select_pins_oe, .strap,
    .master_serial_clock_pin_in, .master_serial_in_pin_in,
    .primary_select_pin_in
  );
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic chk(string what, logic [127:0] e, logic [127:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc_n(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset(logic s);
    rst_n = 1'b0;
    strap = s;
    cyc_n(12);
    rst_n = 1'b1;
    cyc_n(3);
  endtask
  // boot start when b is high, core enable otherwise
  task automatic kick(logic b);
    boot_start = b;
    core_enable = !b;
    cyc_n(1);
    boot_start = 1'b0;
    core_enable = 1'b0;
    cyc_n(2);
  endtask
  task automatic xfer(logic [2:0] s, logic r, logic [4:0] l, logic [4:0] w);
    int k;
    k = 0;
    cmd_select = s;
    cmd_read = r;
    cmd_len = l;
    cmd_wr_len = w;
    cmd_addr = 7'($urandom);
    cmd_wdata = {$urandom, $urandom, $urandom, $urandom};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) cyc_n(1);
    cyc_n(1);
    cmd_valid = 1'b0;
    while (xfer_done !== 1'b1 && k < 40000) begin
      cyc_n(1);
      k++;
    end
    chk("done", 1, xfer_done);
  endtask
  task automatic spi_chk(logic [2:0] s, logic [4:0] l, logic [4:0] w);
    int n;
    logic [6:0] sel;
    n = (l == 0) ? 1 : (l > 16) ? 16 : l;
    cmd_div = 16'($urandom_range(10, 7));
    xfer(s, 1'b0, l, w);
    exp = cmd_wdata;
    for (int k = 0; k < n; k++) begin
      if (k >= w) exp[8*k+:8] = 8'hc3 ^ 8'(k);
      chk("mosi", cmd_wdata[8*k+:8], far.spi_byte[k]);
    end
    chk("rx", exp, rx_data);
    chk("rises", 8 * n, far.rises);
    sel = 7'h7f;
    sel[s] = 1'b0;
    chk("sel", sel, far.sel_seen);
  endtask
  initial begin
    void'($urandom(80));
    do_reset(1'b1);
    chk("en", 0, port_enabled);
    kick(1'b0);
    chk("spi", 7'b1010111, {port_enabled, i2c_active,
        master_serial_out_pin_oe, master_serial_in_pin_oe,
        master_serial_clock_pin_oe, primary_select_pin_oe,
        master_serial_clock_pin_in});
    chk("sec_oe", 6'h00, secondary_select_pins_oe);
    sec_sel_enable = 6'h3f;
    spi_chk(3'h2, 5'h1f, 5'h03);
    for (int i = 0; i < 7; i++)
      spi_chk(3'(i), 5'($urandom_range(4, 1)),
              5'($urandom_range(4, 0)));
    cfg_mode0 = 1'b1;
    cyc_n(4);
    chk("idle0", 0, master_serial_clock_pin_in);
    spi_chk(3'h0, 5'h00, 5'h00);
    do_reset(1'b0);
    kick(1'b1);
    chk("i2c", 5'b11000, {port_enabled, i2c_active,
        master_serial_out_pin_oe, master_serial_clock_pin_out,
        primary_select_pin_oe});
    cmd_div = 16'h009d;
    xfer(3'h0, 1'b0, 5'h01, 5'h00);
    chk("addr", {cmd_addr, 1'b0}, far.i2c_byte[0]);
    chk("wr", cmd_wdata[7:0], far.i2c_byte[1]);
    xfer(3'h0, 1'b1, 5'h02, 5'h00);
    exp = cmd_wdata;
    exp[15:0] = 16'h5b5a;
    chk("rd", exp, rx_data);
    do_reset(1'b1);
    kick(1'b1);
    chk("boot", 2'b10, {port_enabled, i2c_active});
    close_out;
  end
endmodule  // tb
